// ==== pkg/reset_timeout_cfg.svh ====
// constants of the power-on reset time-out sequencer
`ifndef RESET_TIMEOUT_CFG_SVH
`define RESET_TIMEOUT_CFG_SVH

// ****************************************
// timing
// ****************************************
`define RTS_CLOCK_KHZ 50000
`define RTS_POWER_UP_DELAY_TIMER_BITS 11
`define RTS_POWER_UP_DELAY_TIMER_NOM_MS 66
`define RTS_OST_CYCLES 1024
`define RTS_OST_BITS 10
`define RTS_PLL_LOCK_MS 2
`define RTS_PLL_LOCK_CYC (`RTS_PLL_LOCK_MS * `RTS_CLOCK_KHZ)
`define RTS_PLL_BITS 17

// ****************************************
// synchroniser bit positions and divider
// ****************************************
`define RTS_SYNC_POR 0
`define RTS_SYNC_MASTER_CLEAR_N 1
`define RTS_SYNC_RC 2
`define RTS_SYNC_OSC 3
`define RTS_SYNC_PIN 4
`define RTS_SYNC_WIDTH 5
`define RTS_DIV_BIT 1

`endif

// ==== pkg/reset_timeout_pkg.sv ====
// types of the power-on reset time-out sequencer
package reset_timeout_pkg;

  // oscillator configuration codes
  typedef enum logic [3:0] {
    low_power_crystal_mode = 4'h0,
    crystal_mode = 4'h1,
    high_speed_crystal_mode = 4'h2,
    high_speed_pll_mode = 4'h3,
    resistor_capacitor_mode = 4'h4,
    resistor_capacitor_io_mode = 4'h5,
    external_clock_mode = 4'h6,
    external_clock_io_mode = 4'h7,
    internal_osc_mode_a = 4'h8,
    internal_osc_mode_b = 4'h9
  } osc_mode_t;

  // sequencer phases, one-hot
  typedef enum logic [4:0] {
    st_por = 5'h01,
    st_power_up_delay_timer = 5'h02,
    st_ost = 5'h04,
    st_pll = 5'h08,
    st_done = 5'h10
  } seq_state_t;

endpackage : reset_timeout_pkg

// ==== hdl/reset_timeout_sequencer.sv ====
// power-on reset time-out sequencer with oscillator pin handling
`include "reset_timeout_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_sequencer #(
  parameter int PLL_LOCK_CYCLES = `RTS_PLL_LOCK_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic por_pulse,
  input wire logic master_clear_n,
  input wire logic internal_rc_clock,
  input wire logic osc_in_pin,
  input wire logic [3:0] osc_mode,
  input wire logic power_delay_enable_n,
  input wire logic power_managed_exit,
  input wire logic port_a_bit_six_out,
  input wire logic port_a_bit_six_oe,
  input wire logic osc_out_pin_i,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  output logic port_a_bit_six_in,
  output logic device_reset,
  output logic timeout_busy
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [`RTS_SYNC_WIDTH-1:0] pins;
  logic [`RTS_SYNC_WIDTH-1:0] sync1_reg;
  logic [`RTS_SYNC_WIDTH-1:0] sync2_reg;
  logic rc_last_reg;
  logic osc_last_reg;
  logic por_s;
  logic master_clear_n_s;
  logic rc_edge;
  logic osc_edge;
  reset_timeout_pkg::osc_mode_t mode;
  reset_timeout_pkg::seq_state_t state_reg;
  reset_timeout_pkg::seq_state_t state_next;
  logic [`RTS_POWER_UP_DELAY_TIMER_BITS-1:0] power_up_delay_timer_cnt_reg;
  logic [`RTS_OST_BITS-1:0] ost_cnt_reg;
  logic [`RTS_PLL_BITS-1:0] pll_cnt_reg;
  logic [1:0] div_cnt_reg;
  logic power_up_delay_timer_end;
  logic ost_end;
  logic pll_end;
  logic ost_mode;
  logic pll_mode;

  assign pins = {osc_out_pin_i, osc_in_pin, internal_rc_clock, master_clear_n, por_pulse};
  assign mode = reset_timeout_pkg::osc_mode_t'(osc_mode);

  // two flops per pin input
  genvar g;
  generate
    for (g = 0; g < `RTS_SYNC_WIDTH; g++) begin : g_sync
      always_ff @(posedge clock) begin
        if (srst) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pins[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  assign por_s = sync2_reg[`RTS_SYNC_POR];
  assign master_clear_n_s = sync2_reg[`RTS_SYNC_MASTER_CLEAR_N];

  // edge detectors on the synchronised clocks
  always_ff @(posedge clock) begin
    if (srst) begin
      rc_last_reg <= 1'b0;
      osc_last_reg <= 1'b0;
    end else begin
      rc_last_reg <= sync2_reg[`RTS_SYNC_RC];
      osc_last_reg <= sync2_reg[`RTS_SYNC_OSC];
    end
  end

  assign rc_edge = sync2_reg[`RTS_SYNC_RC] & ~rc_last_reg;
  assign osc_edge = sync2_reg[`RTS_SYNC_OSC] & ~osc_last_reg;

  // ****************************************
  // mode classes
  // ****************************************
  // only crystal modes need a start-up count
  assign ost_mode = (mode == reset_timeout_pkg::low_power_crystal_mode)
    || (mode == reset_timeout_pkg::crystal_mode)
    || (mode == reset_timeout_pkg::high_speed_crystal_mode)
    || (mode == reset_timeout_pkg::high_speed_pll_mode);
  assign pll_mode = (mode == reset_timeout_pkg::high_speed_pll_mode);

  assign power_up_delay_timer_end = rc_edge && (power_up_delay_timer_cnt_reg == {`RTS_POWER_UP_DELAY_TIMER_BITS{1'b1}});
  assign ost_end = osc_edge && (ost_cnt_reg == `RTS_OST_BITS'(`RTS_OST_CYCLES - 1));
  assign pll_end = (pll_cnt_reg == `RTS_PLL_BITS'(PLL_LOCK_CYCLES - 1));

  // ****************************************
  // phase sequencing
  // ****************************************
  // next phase from current phase and counter ends
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      reset_timeout_pkg::st_por: begin
        if (!por_s) begin
          if (!power_delay_enable_n) begin
            state_next = reset_timeout_pkg::st_power_up_delay_timer;
          end else if (ost_mode) begin
            state_next = reset_timeout_pkg::st_ost;
          end else begin
            state_next = reset_timeout_pkg::st_done;
          end
        end
      end
      reset_timeout_pkg::st_power_up_delay_timer: begin
        if (power_up_delay_timer_end) begin
          state_next = ost_mode ? reset_timeout_pkg::st_ost
                                : reset_timeout_pkg::st_done;
        end
      end
      reset_timeout_pkg::st_ost: begin
        if (ost_end) begin
          state_next = pll_mode ? reset_timeout_pkg::st_pll
                                : reset_timeout_pkg::st_done;
        end
      end
      reset_timeout_pkg::st_pll: begin
        if (pll_end) begin
          state_next = reset_timeout_pkg::st_done;
        end
      end
      reset_timeout_pkg::st_done: begin
        if (power_managed_exit && ost_mode) begin
          state_next = reset_timeout_pkg::st_ost;
        end
      end
      default: begin
        state_next = reset_timeout_pkg::st_por;
      end
    endcase
    if (por_s) begin
      state_next = reset_timeout_pkg::st_por;
    end
  end

  // phase register
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= reset_timeout_pkg::st_por;
    end else begin
      state_reg <= state_next;
    end
  end

  // power-up delay counter on rc edges
  always_ff @(posedge clock) begin
    if (srst || state_reg != reset_timeout_pkg::st_power_up_delay_timer) begin
      power_up_delay_timer_cnt_reg <= '0;
    end else if (rc_edge) begin
      power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg + 1'b1;
    end
  end

  // oscillator start-up counter on input edges
  always_ff @(posedge clock) begin
    if (srst || state_reg != reset_timeout_pkg::st_ost) begin
      ost_cnt_reg <= '0;
    end else if (osc_edge) begin
      ost_cnt_reg <= ost_cnt_reg + 1'b1;
    end
  end

  // pll lock counter on system clock
  always_ff @(posedge clock) begin
    if (srst || state_reg != reset_timeout_pkg::st_pll) begin
      pll_cnt_reg <= '0;
    end else begin
      pll_cnt_reg <= pll_cnt_reg + 1'b1;
    end
  end

  // reset held by time-outs or master clear
  always_ff @(posedge clock) begin
    if (srst) begin
      device_reset <= 1'b1;
      timeout_busy <= 1'b1;
    end else begin
      device_reset <= (state_next != reset_timeout_pkg::st_done) || !master_clear_n_s;
      timeout_busy <= (state_next != reset_timeout_pkg::st_done);
    end
  end

  // ****************************************
  // second oscillator pin
  // ****************************************
  // divide the input clock by four
  always_ff @(posedge clock) begin
    if (srst) begin
      div_cnt_reg <= 2'h0;
    end else if (osc_edge) begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end

  // pin drive per oscillator mode
  always_ff @(posedge clock) begin
    if (srst) begin
      osc_out_pin_o <= 1'b0;
      osc_out_pin_oe <= 1'b0;
      port_a_bit_six_in <= 1'b0;
    end else begin
      port_a_bit_six_in <= sync2_reg[`RTS_SYNC_PIN];
      if (mode == reset_timeout_pkg::external_clock_mode) begin
        osc_out_pin_o <= div_cnt_reg[`RTS_DIV_BIT];
        osc_out_pin_oe <= 1'b1;
      end else if (mode == reset_timeout_pkg::external_clock_io_mode) begin
        osc_out_pin_o <= port_a_bit_six_out;
        osc_out_pin_oe <= port_a_bit_six_oe;
      end else begin
        osc_out_pin_o <= 1'b0;
        osc_out_pin_oe <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  AST_POR_RESTART: assert property (por_s |=> state_reg == reset_timeout_pkg::st_por)
    else $error("power-on pulse did not restart the sequence");
  AST_HOLD_IN_POWER_UP_DELAY_TIMER: assert property (state_reg == reset_timeout_pkg::st_power_up_delay_timer |-> device_reset)
    else $error("reset released during power-up delay");
  AST_POWER_UP_DELAY_TIMER_SKIP: assert property (state_reg == reset_timeout_pkg::st_por && !por_s
    && power_delay_enable_n |=> state_reg != reset_timeout_pkg::st_power_up_delay_timer)
    else $error("power-up delay ran while disabled");
  AST_POWER_UP_DELAY_TIMER_LEN: assert property (state_reg == reset_timeout_pkg::st_power_up_delay_timer && rc_edge
    && power_up_delay_timer_cnt_reg != 11'h7ff && !por_s |=> state_reg == reset_timeout_pkg::st_power_up_delay_timer)
    else $error("power-up delay ended early");
  AST_OST_ONLY_XTAL: assert property (state_reg == reset_timeout_pkg::st_ost |-> ost_mode)
    else $error("oscillator count in a non-crystal mode");
  AST_PLL_AFTER_OST: assert property ($rose(state_reg == reset_timeout_pkg::st_pll)
    |-> $past(state_reg == reset_timeout_pkg::st_ost) && pll_mode)
    else $error("pll lock phase entered out of order");
  AST_RC_DIRECT: assert property (state_reg == reset_timeout_pkg::st_por && !por_s
    && power_delay_enable_n && mode == reset_timeout_pkg::resistor_capacitor_mode
    |=> state_reg == reset_timeout_pkg::st_done ##1 !device_reset || !master_clear_n_s)
    else $error("rc mode applied a time-out");
  AST_MASTER_CLEAR_N_RELEASE: assert property (state_reg == reset_timeout_pkg::st_done && master_clear_n_s
    && !por_s && !power_managed_exit |=> !device_reset)
    else $error("master clear release did not start execution");
  AST_DIV4_OUT: assert property (mode == reset_timeout_pkg::external_clock_mode
    && $past(mode == reset_timeout_pkg::external_clock_mode)
    |-> osc_out_pin_oe && osc_out_pin_o == $past(div_cnt_reg[1]))
    else $error("divided clock missing on second pin");
  AST_EXTERNAL_CLOCK_IO_MODE_PIN: assert property (mode == reset_timeout_pkg::external_clock_io_mode
    && $past(mode == reset_timeout_pkg::external_clock_io_mode)
    |-> osc_out_pin_o == $past(port_a_bit_six_out))
    else $error("second pin not serving port a bit six");

  COV_FULL_PLL: cover property (state_reg == reset_timeout_pkg::st_pll ##1
    state_reg == reset_timeout_pkg::st_done);
  COV_POWER_UP_DELAY_TIMER_TO_OST: cover property (state_reg == reset_timeout_pkg::st_power_up_delay_timer ##1
    state_reg == reset_timeout_pkg::st_ost);
  COV_PM_EXIT: cover property (state_reg == reset_timeout_pkg::st_done ##1
    state_reg == reset_timeout_pkg::st_ost);

endmodule : reset_timeout_sequencer

`default_nettype wire

// ==== test/clock_source.sv ====
// free-running rc and oscillator sources for the sequencer bench
`timescale 1ns/1ps
`default_nettype none

module clock_source #(
  parameter int RC_HALF = 3,
  parameter int OSC_HALF = 2
) (
  input wire logic clock,
  output logic internal_rc_clock,
  output logic osc_in_pin
);
  int rc_cnt = 0;
  int osc_cnt = 0;

  // ****************************************
  // sources
  // ****************************************
  initial internal_rc_clock = 1'b0;
  initial osc_in_pin = 1'b0;
  // rc source kept below clock/4 so every edge is seen
  always @(posedge clock) begin
    rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
    if (rc_cnt == RC_HALF - 1) internal_rc_clock <= ~internal_rc_clock;
  end
  // oscillator source, period 2*OSC_HALF clocks
  always @(posedge clock) begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1) osc_in_pin <= ~osc_in_pin;
  end
endmodule : clock_source
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench of the reset time-out sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int RP = 6;
  localparam int OP = 4;
  localparam int PLL = 20;
  logic clock, srst, por, master_clear_n_n, pden_n, pm, pa_out, pa_oe, pin_ext;
  logic [3:0] mode;
  logic rc, osc, pin_i, pin_o, pin_oe, pa_in, device_reset, busy, v;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n, k;

  // ****************************************
  // design, sources and pin wiring
  // ****************************************
  clock_source #(.RC_HALF(RP / 2), .OSC_HALF(OP / 2)) u_clock_source (
    .clock(clock), .internal_rc_clock(rc), .osc_in_pin(osc));
  reset_timeout_sequencer #(.PLL_LOCK_CYCLES(PLL)) u_reset_timeout_sequencer (
    .clock(clock), .srst(srst), .por_pulse(por), .master_clear_n(master_clear_n_n),
    .internal_rc_clock(rc), .osc_in_pin(osc), .osc_mode(mode),
    .power_delay_enable_n(pden_n), .power_managed_exit(pm),
    .port_a_bit_six_out(pa_out), .port_a_bit_six_oe(pa_oe), .osc_out_pin_i(pin_i),
    .osc_out_pin_o(pin_o), .osc_out_pin_oe(pin_oe), .port_a_bit_six_in(pa_in),
    .device_reset(device_reset), .timeout_busy(busy));
  assign pin_i = pin_oe ? pin_o : pin_ext; // two-way second pin

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // watchdog on total run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      results();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task tick(int t);
    repeat (t) @(posedge clock);
  endtask : tick

  task chk_bit(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s exp %0b got %0b", nm, e, g);
      err_count++;
    end
  endtask : chk_bit

  task chk_rng(string nm, int lo, int hi, int g);
    n_tests++;
    if (g < lo || g > hi) begin
      $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
      err_count++;
    end
  endtask : chk_rng

  task wait_rel(output int c);
    c = 0;
    while (device_reset !== 1'b0 && c < 40000) begin
      tick(1);
      c++;
    end
  endtask : wait_rel

  task por_hit();
    por <= 1'b1;
    tick(4);
    por <= 1'b0;
  endtask : por_hit

  function automatic int expc(int m, bit en, bit pmx);
    return ((en || pmx) ? 0 : 2048 * RP) + ((m <= 3) ? 1024 * OP : 0) + ((m == 3) ? PLL : 0);
  endfunction : expc

  task chk_time(string nm, int e, int g);
    chk_rng(nm, (e > 12) ? e - 12 : 0, e + 8, g);
  endtask : chk_time

  task results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    srst = 1'b1; por = 1'b1; master_clear_n_n = 1'b1; pden_n = 1'b1; pm = 1'b0;
    pa_out = 1'b0; pa_oe = 1'b0; pin_ext = 1'b0; mode = 4'h4;
    tick(3);
    srst <= 1'b0;
    // every mode, delay off, then a power managed exit
    for (int m = 0; m < 10; m++) begin
      mode <= 4'(m);
      por_hit();
      wait_rel(n);
      chk_time("boot_no_power_up_delay_timer", expc(m, 1, 0), n);
      pm <= 1'b1;
      tick(1);
      pm <= 1'b0;
      tick(1); // let the exit reach device_reset before waiting
      wait_rel(n);
      chk_time("pm_exit", expc(m, 1, 1), n);
    end
    // ext clock with power-up delay only, then divided output
    mode <= 4'h6;
    pden_n <= 1'b0;
    por_hit();
    tick(100);
    chk_bit("reset_in_power_up_delay_timer", 1'b1, device_reset);
    chk_bit("busy_in_power_up_delay_timer", 1'b1, busy);
    wait_rel(n);
    chk_time("ext_power_up_delay_timer", expc(6, 0, 0) - 100, n);
    chk_bit("busy_done", 1'b0, busy);
    v = pin_o;
    k = 0;
    while (pin_o === v && k < 100) begin tick(1); k++; end
    v = pin_o;
    k = 0;
    while (pin_o === v && k < 100) begin tick(1); k++; end
    chk_rng("div4_half_period", 2 * OP, 2 * OP, k);
    chk_bit("ext_pin_oe", 1'b1, pin_oe);
    // high speed with delay: power_up_delay_timer then osc count
    mode <= 4'h2;
    por_hit();
    wait_rel(n);
    chk_time("hs_power_up_delay_timer_ost", expc(2, 0, 0), n);
    // io mode: second pin is port bit six both ways
    mode <= 4'h7;
    pa_out <= 1'b1;
    pa_oe <= 1'b1;
    tick(3);
    chk_bit("io_pin_o", 1'b1, pin_o);
    chk_bit("io_pin_oe", 1'b1, pin_oe);
    pa_oe <= 1'b0;
    pin_ext <= 1'b1;
    tick(6);
    chk_bit("io_pin_oe_off", 1'b0, pin_oe);
    chk_bit("io_pin_in", 1'b1, pa_in);
    // new power-on pulse mid-count restarts the count
    mode <= 4'h1;
    pden_n <= 1'b1;
    por_hit();
    tick(2000);
    por_hit();
    wait_rel(n);
    chk_time("restart", expc(1, 1, 0), n);
    // master clear held low through the oscillator start-up count
    master_clear_n_n <= 1'b0;
    mode <= 4'h0;
    por_hit();
    tick(1024 * OP + 100);
    chk_bit("master_clear_n_busy", 1'b0, busy);
    chk_bit("master_clear_n_reset", 1'b1, device_reset);
    master_clear_n_n <= 1'b1;
    wait_rel(n);
    chk_rng("master_clear_n_release", 0, 5, n);
    results();
  end
endmodule : tb_top
`default_nettype wire
